// ===== common/sfe_pkg.sv
package sfe_pkg;
	// Opcodes
	localparam logic [7:0] OP_SECTOR = 8'h20;
	localparam logic [7:0] OP_HALF = 8'h52;
	localparam logic [7:0] OP_BLOCK = 8'hd8;
	localparam logic [7:0] OP_CHIP_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_B = 8'h60;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE = 8'hab;
	localparam logic [7:0] OP_MAKER_DEV = 8'h90;
	localparam logic [7:0] OP_IDENT = 8'h9f;
	// Frame lengths in bits
	localparam logic [5:0] SHORT_BITS = 6'h08;
	localparam logic [5:0] LONG_BITS = 6'h20;
	localparam logic [5:0] MAX_BITS = 6'h3f;
	// Identity bytes, values arbitrary
	localparam logic [7:0] MAKER_ID = 8'h5a;
	localparam logic [7:0] DEVICE_ID = 8'h33;
	localparam logic [7:0] MEMORY_TYPE = 8'h41;
	localparam logic [7:0] CAPACITY_ID = 8'h15;
	// Erase area alignment masks
	localparam logic [23:0] SECTOR_MASK = 24'hff_f000;
	localparam logic [23:0] HALF_MASK = 24'hff_8000;
	localparam logic [23:0] BLOCK_MASK = 24'hff_0000;
	// Protection counted in 64K blocks from the top of 32
	localparam logic [5:0] ALL_BLOCKS = 6'h20;
	localparam logic [3:0] PROTECT_ALL_CODE = 4'h6;
	// Timing, in microseconds and clock cycles
	localparam int CLOCK_MHZ = 25;
	localparam int SECTOR_ERASE_US = 300;
	localparam int HALF_ERASE_US = 500;
	localparam int BLOCK_ERASE_US = 800;
	localparam int ARRAY_ERASE_US = 4000;
	localparam int SLEEP_ENTRY_US = 3;
	localparam int WAKE_PLAIN_US = 3;
	localparam int WAKE_ID_US = 2;
	localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_US * CLOCK_MHZ;
	localparam int HALF_ERASE_CYCLES = HALF_ERASE_US * CLOCK_MHZ;
	localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_US * CLOCK_MHZ;
	localparam int ARRAY_ERASE_CYCLES = ARRAY_ERASE_US * CLOCK_MHZ;
	localparam int SLEEP_ENTRY_CYCLES = SLEEP_ENTRY_US * CLOCK_MHZ;
	localparam int WAKE_PLAIN_CYCLES = WAKE_PLAIN_US * CLOCK_MHZ;
	localparam int WAKE_ID_CYCLES = WAKE_ID_US * CLOCK_MHZ;

	typedef enum logic [1:0] {
		ERASE_SECTOR,
		ERASE_HALF,
		ERASE_BLOCK,
		ERASE_CHIP
	} sfe_erase_kind_type;

	typedef enum {
		PHASE_AWAKE,
		PHASE_ERASING,
		PHASE_ENTERING,
		PHASE_ASLEEP,
		PHASE_WAKING
	} sfe_phase_type;

	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] address;
		logic [5:0] bits;
	} sfe_frame_type;

	typedef struct packed {
		sfe_erase_kind_type kind;
		logic [23:0] base;
	} sfe_erase_type;
endpackage : sfe_pkg

// ===== core/sfe_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_sequencer
	import sfe_pkg::*;
#(
	parameter int SECTOR_CYCLES = sfe_pkg::SECTOR_ERASE_CYCLES,
	parameter int HALF_CYCLES = sfe_pkg::HALF_ERASE_CYCLES,
	parameter int BLOCK_CYCLES = sfe_pkg::BLOCK_ERASE_CYCLES,
	parameter int ARRAY_CYCLES = sfe_pkg::ARRAY_ERASE_CYCLES,
	parameter int ENTRY_CYCLES = sfe_pkg::SLEEP_ENTRY_CYCLES,
	parameter int PLAIN_CYCLES = sfe_pkg::WAKE_PLAIN_CYCLES,
	parameter int ID_CYCLES = sfe_pkg::WAKE_ID_CYCLES,
	parameter logic [7:0] MAKER = sfe_pkg::MAKER_ID,
	parameter logic [7:0] DEVICE = sfe_pkg::DEVICE_ID,
	parameter logic [7:0] MEM_TYPE = sfe_pkg::MEMORY_TYPE,
	parameter logic [7:0] CAPACITY = sfe_pkg::CAPACITY_ID
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic link_clock,
	input wire logic select_n,
	input wire logic serial_io_line,
	input wire logic protect_bit_3,
	input wire logic protect_bit_2,
	input wire logic protect_bit_1,
	input wire logic protect_bit_0,
	input wire logic wel_set,
	output logic serial_out,
	output logic serial_out_oe,
	output logic write_enable_latch,
	output logic busy,
	output logic sleeping,
	output logic erase_go,
	output sfe_pkg::sfe_erase_type erase_req
);
	import sfe_pkg::*;

	// Link domain
	sfe_frame_type frame;
	logic [31:0] shift;
	logic in_frame;
	logic frame_toggle;
	logic link_busy_s1;
	logic link_busy;
	logic link_sleep_s1;
	logic link_sleep;
	logic [2:0] out_bit;
	logic [1:0] out_byte;

	// Clock domain
	sfe_phase_type phase;
	sfe_phase_type next_phase;
	logic [31:0] remaining;
	logic [31:0] next_remaining;
	logic [2:0] select_sync;
	logic toggle_s1;
	logic toggle_s2;
	logic toggle_seen;
	logic next_wel;

	// Busy and sleep reach the link side through two flops; busy rises just
	// after a frame end, but both also change on timer expiry, which can fall inside a frame.
	always_ff @(posedge link_clock) begin
		link_busy_s1 <= busy;
		link_busy <= link_busy_s1;
		link_sleep_s1 <= sleeping;
		link_sleep <= link_sleep_s1;
	end

	// Cleared by select high, so a frame needs no clock after its end
	always_ff @(posedge link_clock or posedge select_n) begin
		if (select_n) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	// One toggle per frame marks that clocks really arrived
	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			frame_toggle <= 1'b0;
		end else if (!in_frame) begin
			frame_toggle <= !frame_toggle;
		end
	end

	wire [31:0] shifted = {shift[30:0], serial_io_line};

	always_ff @(posedge link_clock) begin
		shift <= shifted;
		if (!in_frame) begin
			frame.bits <= 6'h01;
		end else if (frame.bits != MAX_BITS) begin
			frame.bits <= frame.bits + 6'h01;
		end
		if (in_frame && frame.bits == SHORT_BITS - 6'h01) begin
			frame.opcode <= shifted[7:0];
		end
		if (in_frame && frame.bits == LONG_BITS - 6'h01) begin
			frame.address <= shifted[23:0];
		end
	end

	// Reply selection on the link side
	wire opcode_in = frame.bits >= SHORT_BITS;
	wire address_in = frame.bits >= LONG_BITS;
	wire reply_ident = opcode_in && frame.opcode == OP_IDENT && !link_sleep;
	wire reply_pair = address_in && frame.opcode == OP_MAKER_DEV &&
		!link_sleep;
	wire reply_dev = address_in && frame.opcode == OP_WAKE && !link_busy;
	wire reply_active = reply_ident || reply_pair || reply_dev;
	wire pair_device = out_byte[0] ^ frame.address[0];
	wire [7:0] ident_byte = (out_byte == 2'h0) ? MAKER :
		(out_byte == 2'h1) ? MEM_TYPE : CAPACITY;
	wire [7:0] pair_byte = pair_device ? DEVICE : MAKER;
	wire [7:0] reply_byte = reply_ident ? ident_byte :
		reply_pair ? pair_byte : DEVICE;
	wire [1:0] next_byte = (reply_ident && out_byte == 2'h2) ? 2'h0 :
		out_byte + 2'h1;

	// Replies go out MSB first on the falling edge
	always_ff @(negedge link_clock or posedge select_n) begin
		if (select_n) begin
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
			out_bit <= 3'h0;
			out_byte <= 2'h0;
		end else if (reply_active) begin
			serial_out <= reply_byte[3'h7 - out_bit];
			serial_out_oe <= 1'b1;
			out_bit <= out_bit + 3'h1;
			if (out_bit == 3'h7) begin
				out_byte <= next_byte;
			end
		end
	end

	// Frame end seen in the clock domain
	always_ff @(posedge clock) begin
		select_sync <= {select_sync[1:0], select_n};
		toggle_s1 <= frame_toggle;
		toggle_s2 <= toggle_s1;
		if (reset) begin
			toggle_seen <= 1'b0;
		end else if (select_sync[1] && !select_sync[2]) begin
			toggle_seen <= toggle_s2;
		end
	end

	// The link frame is static here: its clock has stopped
	wire frame_end = select_sync[1] && !select_sync[2] &&
		toggle_s2 != toggle_seen;
	wire [7:0] op = frame.opcode;
	wire short_frame = frame.bits == SHORT_BITS;
	wire long_frame = frame.bits == LONG_BITS;
	wire [3:0] protect = {protect_bit_3, protect_bit_2, protect_bit_1,
		protect_bit_0};
	wire [5:0] protect_blocks = (protect == 4'h0) ? 6'h00 :
		(protect >= PROTECT_ALL_CODE) ? ALL_BLOCKS :
		6'h01 << (protect - 4'h1);
	wire area_protected = protect_blocks != 6'h00 &&
		{1'b0, frame.address[20:16]} >= ALL_BLOCKS - protect_blocks;
	wire area_op = op == OP_SECTOR || op == OP_HALF || op == OP_BLOCK;
	wire chip_op = op == OP_CHIP_A || op == OP_CHIP_B;
	wire awake_cmd = frame_end && phase == PHASE_AWAKE;
	wire area_erase = awake_cmd && write_enable_latch && long_frame &&
		area_op && !area_protected;
	wire chip_erase = awake_cmd && write_enable_latch && short_frame &&
		chip_op && protect == 4'h0;
	wire start_erase = area_erase || chip_erase;
	wire sleep_cmd = awake_cmd && short_frame && op == OP_SLEEP;
	wire asleep_wake = frame_end && phase == PHASE_ASLEEP &&
		op == OP_WAKE;
	wire wake_plain = asleep_wake && short_frame;
	wire wake_id = asleep_wake && frame.bits >= LONG_BITS;
	wire timer_done = remaining == 32'h0000_0000;

	wire sfe_erase_kind_type kind = chip_op ? ERASE_CHIP :
		(op == OP_SECTOR) ? ERASE_SECTOR :
		(op == OP_HALF) ? ERASE_HALF : ERASE_BLOCK;
	wire [23:0] base = (kind == ERASE_SECTOR) ?
		frame.address & SECTOR_MASK :
		(kind == ERASE_HALF) ? frame.address & HALF_MASK :
		(kind == ERASE_BLOCK) ? frame.address & BLOCK_MASK :
		24'h00_0000;
	wire [31:0] erase_load = (kind == ERASE_SECTOR) ?
		32'(SECTOR_CYCLES - 1) : (kind == ERASE_HALF) ?
		32'(HALF_CYCLES - 1) : (kind == ERASE_BLOCK) ?
		32'(BLOCK_CYCLES - 1) : 32'(ARRAY_CYCLES - 1);

	always_comb begin
		next_phase = phase;
		next_remaining = timer_done ? remaining :
			remaining - 32'h0000_0001;
		unique case (phase)
			PHASE_AWAKE: begin
				if (start_erase) begin
					next_phase = PHASE_ERASING;
					next_remaining = erase_load;
				end else if (sleep_cmd) begin
					next_phase = PHASE_ENTERING;
					next_remaining = 32'(ENTRY_CYCLES - 1);
				end
			end
			PHASE_ERASING: begin
				if (timer_done) begin
					next_phase = PHASE_AWAKE;
				end
			end
			PHASE_ENTERING: begin
				if (timer_done) begin
					next_phase = PHASE_ASLEEP;
				end
			end
			PHASE_ASLEEP: begin
				if (wake_plain) begin
					next_phase = PHASE_WAKING;
					next_remaining = 32'(PLAIN_CYCLES - 1);
				end else if (wake_id) begin
					next_phase = PHASE_WAKING;
					next_remaining = 32'(ID_CYCLES - 1);
				end
			end
			PHASE_WAKING: begin
				if (timer_done) begin
					next_phase = PHASE_AWAKE;
				end
			end
		endcase
	end

	// A set arriving with the completion wins
	assign next_wel = wel_set ? 1'b1 :
		(phase == PHASE_ERASING && timer_done) ? 1'b0 :
		write_enable_latch;

	always_ff @(posedge clock) begin
		if (reset) begin
			phase <= PHASE_AWAKE;
			remaining <= 32'h0000_0000;
			write_enable_latch <= 1'b0;
			busy <= 1'b0;
			sleeping <= 1'b0;
			erase_go <= 1'b0;
			erase_req <= '0;
		end else begin
			phase <= next_phase;
			remaining <= next_remaining;
			write_enable_latch <= next_wel;
			busy <= next_phase == PHASE_ERASING;
			sleeping <= next_phase == PHASE_ASLEEP ||
				next_phase == PHASE_WAKING;
			erase_go <= start_erase;
			if (start_erase) begin
				erase_req <= '{kind: kind, base: base};
			end
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	sequence s_sleep_cmd;
		phase == PHASE_AWAKE && frame_end && op == OP_SLEEP &&
			frame.bits == SHORT_BITS;
	endsequence

	sequence s_wake_plain;
		phase == PHASE_ASLEEP && frame_end && op == OP_WAKE &&
			frame.bits == SHORT_BITS;
	endsequence

	a_wel_gates_erase: assert property (
		$rose(erase_go) |-> $past(write_enable_latch))
		else $error("erase started without write enable");
	a_erase_sets_busy: assert property (
		erase_go |-> busy ##1 (busy || $past(timer_done)))
		else $error("busy not held for erase");
	a_busy_ends_timed: assert property (
		$fell(busy) |-> $past(remaining) == 32'h0000_0000)
		else $error("busy dropped before timer expiry");
	a_wel_cleared_end: assert property (
		$fell(busy) && !$past(wel_set) |-> !write_enable_latch)
		else $error("write enable latch survived erase");
	a_sector_aligned: assert property (
		erase_go && erase_req.kind == ERASE_SECTOR |->
			erase_req.base[11:0] == 12'h000)
		else $error("sector erase base misaligned");
	a_block_aligned: assert property (
		erase_go && erase_req.kind == ERASE_BLOCK |->
			erase_req.base[15:0] == 16'h0000)
		else $error("block erase base misaligned");
	a_chip_unprotected: assert property (
		erase_go && erase_req.kind == ERASE_CHIP |-> $past(protect) == 4'h0)
		else $error("chip erase ran with protection set");
	a_exact_length: assert property (
		frame_end && frame.bits != SHORT_BITS && frame.bits != LONG_BITS
			|=> !erase_go)
		else $error("erase accepted on ragged frame");
	a_protected_area: assert property (
		frame_end && area_op && area_protected |=> !erase_go)
		else $error("erase of protected area accepted");
	a_sleep_entry: assert property (
		s_sleep_cmd |=> phase == PHASE_ENTERING ##0 !sleeping)
		else $error("sleep command not taken");
	a_asleep_ignores: assert property (
		phase == PHASE_ASLEEP && frame_end && op != OP_WAKE |=>
			phase == PHASE_ASLEEP && sleeping)
		else $error("asleep device acted on other opcode");
	a_wake_plain: assert property (
		s_wake_plain |=> phase == PHASE_WAKING && sleeping)
		else $error("wake command not taken");
	a_busy_ignores_wake: assert property (
		phase == PHASE_ERASING && !timer_done && frame_end |=>
			phase == PHASE_ERASING && busy)
		else $error("erase disturbed by command");
	a_power_up_awake: assert property (
		disable iff (1'b0) reset |=> !sleeping && !busy)
		else $error("device not awake after reset");
endmodule : sfe_sequencer
`default_nettype wire

// ===== bench/sfe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_host_model (
	output logic link_clock,
	output logic select_n,
	output logic serial_io_line,
	input wire logic serial_out
);
	initial begin
		link_clock = 1'b0;
		select_n = 1'b1;
		serial_io_line = 1'b0;
	end

	// Clock runs only inside frames, 32 ns period
	task automatic frame(input logic [7:0] op, input logic [23:0] adr,
		input int nb, input int nr, output logic [23:0] rd);
		logic [31:0] w;
		w = {op, adr};
		rd = 24'h00_0000;
		select_n = 1'b0;
		#20;
		for (int i = 0; i < nb + nr; i++) begin
			// Set on the low phase, taken on the rise
			serial_io_line = (i < nb) ? w[31 - i] : ~serial_io_line;
			#16 link_clock = 1'b1;
			if (i >= nb)
				rd = {rd[22:0], serial_out};
			#16 link_clock = 1'b0;
		end
		// Ends exactly where the caller's bit count ends
		#20 select_n = 1'b1;
		// Released line must not keep its last value
		serial_io_line = ~serial_io_line;
		// Select stays high for at least 160 ns before the next frame
		#160;
	endtask : frame
endmodule : sfe_host_model
`default_nettype wire

// ===== bench/test_sfe_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_sfe_sequencer;
	import sfe_pkg::*;
	localparam int PLAIN = 40;
	localparam int IDW = 20;
	logic clock, reset, link_clock, select_n, serial_io_line, wel_set;
	logic [3:0] protect;
	logic serial_out, write_enable_latch, busy, sleeping, erase_go;
	logic serial_out_oe;
	sfe_erase_type erase_req;
	int error_cnt, check_count, seed, n, oe_base;
	int oe_count = 0;
	logic [23:0] rd, a;
	logic [7:0] ops [5] = '{OP_SECTOR, OP_HALF, OP_BLOCK, OP_CHIP_A, OP_CHIP_B};
	int kinds [5] = '{0, 1, 2, 3, 3};

	// Distinct erase durations so a swapped count shows
	sfe_sequencer #(.SECTOR_CYCLES(40), .HALF_CYCLES(50), .BLOCK_CYCLES(60),
		.ARRAY_CYCLES(70), .ENTRY_CYCLES(20), .PLAIN_CYCLES(PLAIN),
		.ID_CYCLES(IDW)) sfe_sequencer_inst (.clock(clock), .reset(reset),
		.link_clock(link_clock), .select_n(select_n),
		.serial_io_line(serial_io_line), .protect_bit_3(protect[3]),
		.protect_bit_2(protect[2]), .protect_bit_1(protect[1]),
		.protect_bit_0(protect[0]), .wel_set(wel_set),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.write_enable_latch(write_enable_latch), .busy(busy),
		.sleeping(sleeping), .erase_go(erase_go), .erase_req(erase_req));
	sfe_host_model sfe_host_model_inst (.link_clock(link_clock),
		.select_n(select_n), .serial_io_line(serial_io_line),
		.serial_out(serial_out));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Reply enable is counted where the host samples the reply bits
	always @(posedge link_clock) begin
		if (serial_out_oe === 1'b1) begin
			oe_count++;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task conclude;
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	task automatic erase(input logic [7:0] op, input logic [23:0] adr,
		input int nb, input int k, input bit ok, input bit poke);
		int sz;
		logic go;
		sz = (k == 0) ? 4096 : (k == 1) ? 32768 : 65536;
		go = 1'b0;
		n = 0;
		@(negedge clock) wel_set = 1'b1;
		@(negedge clock) wel_set = 1'b0;
		// Start pulse is one cycle and comes before the host returns
		fork
			begin
				sfe_host_model_inst.frame(op, adr, nb, 0, rd);
				if (poke) begin
					sfe_host_model_inst.frame(OP_WAKE, 24'h00_0000, 8, 0, rd);
				end
			end
			begin
				for (int i = 0; i < 48 && go !== 1'b1; i++) begin
					@(negedge clock);
					go = erase_go;
				end
				while (go === 1'b1 && busy === 1'b1 && n < 200) begin
					n++;
					@(negedge clock);
				end
			end
		join
		check(32'(go), 32'(ok));
		if (go === 1'b1) begin
			if (k < 3)
				check(32'(erase_req), {6'h00, k[1:0], 24'(adr & ~(sz - 1))});
			else
				check(32'(erase_req.kind), 32'(k));
			check(32'(n), 32'(40 + 10 * k));
			check(32'(write_enable_latch), 32'h0000_0000);
			check(32'(sleeping), 32'h0000_0000);
		end
		repeat (4) @(negedge clock);
	endtask : erase

	// Wake delay measured from the end of the frame
	task automatic wake(input int nb, input int nr, input int lim);
		sfe_host_model_inst.frame(OP_WAKE, 24'h00_0000, nb, nr, rd);
		n = 0;
		while (sleeping === 1'b1 && n < 200) begin
			n++;
			@(negedge clock);
		end
		check(32'(n >= lim - 4 && n <= lim + 6), 32'h0000_0001);
	endtask : wake

	task automatic nap;
		sfe_host_model_inst.frame(OP_SLEEP, 24'h00_0000, 8, 0, rd);
		repeat (28) @(negedge clock);
		check(32'(sleeping), 32'h0000_0001);
	endtask : nap

	initial begin
		seed = 66;
		error_cnt = 0;
		check_count = 0;
		reset = 1'b1;
		wel_set = 1'b0;
		protect = 4'h0;
		repeat (16) @(negedge clock);
		reset = 1'b0;
		repeat (2) @(negedge clock);
		check({29'h0, busy, sleeping, write_enable_latch}, 32'h0000_0000);
		sfe_host_model_inst.frame(OP_SECTOR, 24'h00_1000, 32, 0, rd);
		repeat (10) @(negedge clock);
		check(32'(busy), 32'h0000_0000);
		for (int j = 0; j < 5; j++) begin
			a = 24'($random(seed));
			erase(ops[j], a, (j < 3) ? 32 : 8, kinds[j], 1'b1, j == 0);
		end
		erase(OP_SECTOR, 24'($random(seed)), 31, 0, 1'b0, 1'b0);
		erase(OP_CHIP_A, 24'h00_0000, 16, 3, 1'b0, 1'b0);
		@(negedge clock) protect = 4'h1;
		erase(OP_SECTOR, 24'h1f_2000, 32, 0, 1'b0, 1'b0);
		erase(OP_BLOCK, 24'h1e_4000, 32, 2, 1'b1, 1'b0);
		erase(OP_CHIP_B, 24'h00_0000, 8, 3, 1'b0, 1'b0);
		@(negedge clock) protect = 4'h6;
		erase(OP_HALF, 24'h00_0000, 32, 1, 1'b0, 1'b0);
		@(negedge clock) protect = 4'h0;
		oe_base = oe_count;
		sfe_host_model_inst.frame(OP_IDENT, 24'h00_0000, 8, 24, rd);
		check(32'(rd), {8'h00, MAKER_ID, MEMORY_TYPE, CAPACITY_ID});
		check(32'(oe_count - oe_base), 32'h0000_0018);
		check(32'(serial_out_oe), 32'h0000_0000);
		sfe_host_model_inst.frame(OP_MAKER_DEV, 24'h00_0000, 32, 16, rd);
		check(32'(rd[15:0]), {16'h0000, MAKER_ID, DEVICE_ID});
		sfe_host_model_inst.frame(OP_MAKER_DEV, 24'h00_0001, 32, 24, rd);
		check(32'(rd), {8'h00, DEVICE_ID, MAKER_ID, DEVICE_ID});
		a = 24'($random(seed));
		sfe_host_model_inst.frame(OP_WAKE, a, 32, 24, rd);
		check(32'(rd), {8'h00, DEVICE_ID, DEVICE_ID, DEVICE_ID});
		nap();
		oe_base = oe_count;
		sfe_host_model_inst.frame(OP_IDENT, 24'h00_0000, 8, 24, rd);
		check(32'(rd), 32'h0000_0000);
		check(32'(oe_count - oe_base), 32'h0000_0000);
		erase(OP_SECTOR, 24'h00_0000, 32, 0, 1'b0, 1'b0);
		wake(8, 0, PLAIN);
		erase(OP_HALF, 24'($random(seed)), 32, 1, 1'b1, 1'b0);
		nap();
		wake(32, 16, IDW);
		conclude();
	end

	// Whole run is well under a millisecond
	initial begin
		#2000000;
		error_cnt++;
		conclude();
	end
endmodule : test_sfe_sequencer
`default_nettype wire
